// ===== logic/dsaf_top.sv
// Purpose: Status/control byte and alarm/warning flag bytes of the monitor.
// Assumes: Register port is the decoded byte access of the management page.
// Notes:   Reads return data one cycle after the request, from a flop.

// Functional notes
// - Bit 7 reads transmit shutoff state
// - Bit 6 read/write, drives transmit shutoff
// - Bit 1 mirrors receive signal lost pin
// - Bit 0 low once data ready
// - Temperature alarms in byte 112 bits 7,6
// - Supply alarms in byte 112 bits 5,4
// - Bias alarms in byte 112 bits 3,2
// - Tx power alarms byte 112 bits 1,0
// - Rx power alarms byte 113, rest reserved
// - Temperature warnings byte 116 bits 7,6
// - Supply warnings byte 116 bits 5,4
// - Bias warnings byte 116 bits 3,2
// - Tx power warnings byte 116 bits 1,0
// - Rx power warnings byte 117, rest reserved
// - Default temperature limits 110,-45,95,-42 C
// - Temperature is signed, 1/256 degree steps
module dsaf_top (
  input  wire logic        ref_clk,             // System clock, 20 MHz
  input  wire logic        rst_b,               // Async reset, active low
  input  wire logic [15:0] temp_meas,           // Temperature, signed
  input  wire logic [15:0] vcc_meas,            // Supply voltage
  input  wire logic [15:0] bias_meas,           // Emitter bias current
  input  wire logic [15:0] txpwr_meas,          // Transmit power
  input  wire logic [15:0] rxpwr_meas,          // Receive power
  input  wire logic        meas_strobe,         // Measurements fresh
  input  wire logic        receive_signal_lost, // Loss of signal pin
  input  wire logic [7:0]  reg_addr,            // Byte offset
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic [7:0]  reg_wdata,           // Write data
  input  wire logic        reg_rd,              // Read strobe
  output logic      [7:0]  reg_rdata,           // Read data
  output logic             reg_rvalid,          // Read data valid
  output logic             tx_shutoff           // Soft transmit shutoff
);

  // Measurements gathered by channel index
  logic [15:0] meas [dsaf_pkg::DSAF_NCH];

  // Raw comparison results per channel
  logic [dsaf_pkg::DSAF_NCH-1:0] alm_hi_c;  // Above high alarm
  logic [dsaf_pkg::DSAF_NCH-1:0] alm_lo_c;  // Below low alarm
  logic [dsaf_pkg::DSAF_NCH-1:0] wrn_hi_c;  // Above high warning
  logic [dsaf_pkg::DSAF_NCH-1:0] wrn_lo_c;  // Below low warning

  // Registered flags per channel
  logic [dsaf_pkg::DSAF_NCH-1:0] alm_hi_q;  // High alarm flags
  logic [dsaf_pkg::DSAF_NCH-1:0] alm_lo_q;  // Low alarm flags
  logic [dsaf_pkg::DSAF_NCH-1:0] wrn_hi_q;  // High warning flags
  logic [dsaf_pkg::DSAF_NCH-1:0] wrn_lo_q;  // Low warning flags

  // Assembled flag bytes as the host sees them
  logic [7:0] alm0_byte;   // Alarm byte, first four channels
  logic [7:0] alm1_byte;   // Alarm byte, receive power
  logic [7:0] wrn0_byte;   // Warning byte, first four channels
  logic [7:0] wrn1_byte;   // Warning byte, receive power
  logic [7:0] ctrl_byte;   // Status/control byte

  logic       soft_q;      // Soft transmit shutoff bit
  logic       nrdy;        // Data not yet valid, active low ready
  logic [7:0] rdata_d;     // Read mux output
  logic [7:0] rdata_q;     // Read data flop
  logic       rvalid_q;    // Read answer flag

  // Channel ordering of the measurement inputs
  assign meas[dsaf_pkg::DSAF_CH_TEMP]  = temp_meas;
  assign meas[dsaf_pkg::DSAF_CH_VCC]   = vcc_meas;
  assign meas[dsaf_pkg::DSAF_CH_BIAS]  = bias_meas;
  assign meas[dsaf_pkg::DSAF_CH_TXPWR] = txpwr_meas;
  assign meas[dsaf_pkg::DSAF_CH_RXPWR] = rxpwr_meas;

  // One alarm and one warning comparator pair per channel
  // Only temperature compares signed; the rest are unsigned counts
  for (genvar ch = 0; ch < dsaf_pkg::DSAF_NCH; ch++) begin : g_chan
    // Alarm limits
    dsaf_compare #(
      .IS_SIGNED (ch == dsaf_pkg::DSAF_CH_TEMP),
      .LIM_HI    (dsaf_pkg::DSAF_ALM_HI[ch]),
      .LIM_LO    (dsaf_pkg::DSAF_ALM_LO[ch])
    ) u_alm (
      .value    (meas[ch]),
      .over_hi  (alm_hi_c[ch]),
      .under_lo (alm_lo_c[ch])
    );
    // Warning limits
    dsaf_compare #(
      .IS_SIGNED (ch == dsaf_pkg::DSAF_CH_TEMP),
      .LIM_HI    (dsaf_pkg::DSAF_WRN_HI[ch]),
      .LIM_LO    (dsaf_pkg::DSAF_WRN_LO[ch])
    ) u_wrn (
      .value    (meas[ch]),
      .over_hi  (wrn_hi_c[ch]),
      .under_lo (wrn_lo_c[ch])
    );
  end

  // Flags follow the latest comparison; they are not sticky
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alm_hi_q <= dsaf_pkg::DSAF_FLAG_RST;
      alm_lo_q <= dsaf_pkg::DSAF_FLAG_RST;
      wrn_hi_q <= dsaf_pkg::DSAF_FLAG_RST;
      wrn_lo_q <= dsaf_pkg::DSAF_FLAG_RST;
    end else if (meas_strobe) begin
      alm_hi_q <= alm_hi_c;
      alm_lo_q <= alm_lo_c;
      wrn_hi_q <= wrn_hi_c;
      wrn_lo_q <= wrn_lo_c;
    end
  end

  // Alarm bytes: high/low pairs, temperature in the top pair
  assign alm0_byte = {alm_hi_q[0], alm_lo_q[0],
                      alm_hi_q[1], alm_lo_q[1],
                      alm_hi_q[2], alm_lo_q[2],
                      alm_hi_q[3], alm_lo_q[3]};
  assign alm1_byte = {alm_hi_q[4], alm_lo_q[4], 6'h00};

  // Warning bytes in the same layout
  assign wrn0_byte = {wrn_hi_q[0], wrn_lo_q[0],
                      wrn_hi_q[1], wrn_lo_q[1],
                      wrn_hi_q[2], wrn_lo_q[2],
                      wrn_hi_q[3], wrn_lo_q[3]};
  assign wrn1_byte = {wrn_hi_q[4], wrn_lo_q[4], 6'h00};

  // Readiness tracker
  dsaf_ready u_ready (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .meas_strobe  (meas_strobe),
    .data_valid_n (nrdy)
  );

  // Soft shutoff: only bit 6 of the control byte is writable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_q <= dsaf_pkg::DSAF_SOFT_RST;
    end else if (reg_wr && reg_addr == dsaf_pkg::DSAF_CTRL_OFS) begin
      soft_q <= reg_wdata[dsaf_pkg::DSAF_TXS_SOFT_BIT];
    end
  end

  // Shutoff output follows the soft bit directly
  assign tx_shutoff = soft_q;

  // Status/control byte; reserved bits 5..2 read zero
  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[dsaf_pkg::DSAF_TXS_STATE_BIT] = soft_q;
    ctrl_byte[dsaf_pkg::DSAF_TXS_SOFT_BIT]  = soft_q;
    ctrl_byte[dsaf_pkg::DSAF_LOS_BIT]       = receive_signal_lost;
    ctrl_byte[dsaf_pkg::DSAF_NRDY_BIT]      = nrdy;
  end

  // Read decode; unmapped offsets answer zero
  always_comb begin
    unique case (reg_addr)
      dsaf_pkg::DSAF_CTRL_OFS: rdata_d = ctrl_byte;
      dsaf_pkg::DSAF_ALM0_OFS: rdata_d = alm0_byte;
      dsaf_pkg::DSAF_ALM1_OFS: rdata_d = alm1_byte;
      dsaf_pkg::DSAF_WRN0_OFS: rdata_d = wrn0_byte;
      dsaf_pkg::DSAF_WRN1_OFS: rdata_d = wrn1_byte;
      default:                 rdata_d = dsaf_pkg::DSAF_UNMAPPED;
    endcase
  end

  // Read data captured on the request and held until the next one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= dsaf_pkg::DSAF_RDATA_RST;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Answer flag is a one-cycle pulse after each read request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Read of one offset with no measurement update in the same cycle
  sequence s_rd(logic [7:0] ofs);
    reg_rd && !meas_strobe && !reg_wr && reg_addr == ofs;
  endsequence

  // Measurement taken, then read of an offset in the next cycle
  sequence s_meas_rd(logic [7:0] ofs);
    meas_strobe ##1 s_rd(ofs);
  endsequence

  // State bit matches shutoff output seen at the read
  a_tx_state_rd: assert property (
    s_rd(dsaf_pkg::DSAF_CTRL_OFS) |=> reg_rdata[7] == $past(tx_shutoff)
  ) else $error("Shutoff state bit wrong");

  // A write to bit 6, one idle cycle, then a read back of the same byte
  a_soft_write: assert property (
    reg_wr && reg_addr == dsaf_pkg::DSAF_CTRL_OFS ##1 !reg_wr ##1 s_rd(dsaf_pkg::DSAF_CTRL_OFS)
    |=> reg_rdata[6] == $past(reg_wdata[6], 3) && tx_shutoff == reg_rdata[6]
  ) else $error("Soft shutoff write lost");

  // Loss of signal bit follows the pin
  a_los_mirror: assert property (
    s_rd(dsaf_pkg::DSAF_CTRL_OFS) |=> reg_rdata[1] == $past(receive_signal_lost)
  ) else $error("Loss of signal bit wrong");

  // After a measurement the not-ready bit reads low
  a_ready_low: assert property (
    s_meas_rd(dsaf_pkg::DSAF_CTRL_OFS) |=> !reg_rdata[0]
  ) else $error("Ready bit not low");

  // Temperature alarm pair tracks signed compare against limits
  a_temp_alarm: assert property (
    s_meas_rd(dsaf_pkg::DSAF_ALM0_OFS) |=> reg_rdata[7:6] ==
      {$signed($past(temp_meas, 2)) > $signed(dsaf_pkg::DSAF_TEMP_ALM_HI),
       $signed($past(temp_meas, 2)) < $signed(dsaf_pkg::DSAF_TEMP_ALM_LO)}
  ) else $error("Temperature alarm pair wrong");

  // Supply alarm pair
  a_vcc_alarm: assert property (
    s_meas_rd(dsaf_pkg::DSAF_ALM0_OFS) |=> reg_rdata[5:4] ==
      {$past(vcc_meas, 2) > dsaf_pkg::DSAF_ALM_HI[1],
       $past(vcc_meas, 2) < dsaf_pkg::DSAF_ALM_LO[1]}
  ) else $error("Supply alarm pair wrong");

  // Bias alarm pair
  a_bias_alarm: assert property (
    s_meas_rd(dsaf_pkg::DSAF_ALM0_OFS) |=> reg_rdata[3:2] ==
      {$past(bias_meas, 2) > dsaf_pkg::DSAF_ALM_HI[2],
       $past(bias_meas, 2) < dsaf_pkg::DSAF_ALM_LO[2]}
  ) else $error("Bias alarm pair wrong");

  // Transmit power alarm pair
  a_txpwr_alarm: assert property (
    s_meas_rd(dsaf_pkg::DSAF_ALM0_OFS) |=> reg_rdata[1:0] ==
      {$past(txpwr_meas, 2) > dsaf_pkg::DSAF_ALM_HI[3],
       $past(txpwr_meas, 2) < dsaf_pkg::DSAF_ALM_LO[3]}
  ) else $error("Transmit power alarm pair wrong");

  // Receive power alarm byte with reserved bits clear
  a_rxpwr_alarm: assert property (
    s_meas_rd(dsaf_pkg::DSAF_ALM1_OFS) |=> reg_rdata ==
      {$past(rxpwr_meas, 2) > dsaf_pkg::DSAF_ALM_HI[4],
       $past(rxpwr_meas, 2) < dsaf_pkg::DSAF_ALM_LO[4], 6'h00}
  ) else $error("Receive power alarm byte wrong");

  // Temperature warning pair
  a_temp_warn: assert property (
    s_meas_rd(dsaf_pkg::DSAF_WRN0_OFS) |=> reg_rdata[7:6] ==
      {$signed($past(temp_meas, 2)) > $signed(dsaf_pkg::DSAF_TEMP_WRN_HI),
       $signed($past(temp_meas, 2)) < $signed(dsaf_pkg::DSAF_TEMP_WRN_LO)}
  ) else $error("Temperature warning pair wrong");

  // Supply warning pair
  a_vcc_warn: assert property (
    s_meas_rd(dsaf_pkg::DSAF_WRN0_OFS) |=> reg_rdata[5:4] ==
      {$past(vcc_meas, 2) > dsaf_pkg::DSAF_WRN_HI[1],
       $past(vcc_meas, 2) < dsaf_pkg::DSAF_WRN_LO[1]}
  ) else $error("Supply warning pair wrong");

  // Bias warning pair
  a_bias_warn: assert property (
    s_meas_rd(dsaf_pkg::DSAF_WRN0_OFS) |=> reg_rdata[3:2] ==
      {$past(bias_meas, 2) > dsaf_pkg::DSAF_WRN_HI[2],
       $past(bias_meas, 2) < dsaf_pkg::DSAF_WRN_LO[2]}
  ) else $error("Bias warning pair wrong");

  // Transmit power warning pair
  a_txpwr_warn: assert property (
    s_meas_rd(dsaf_pkg::DSAF_WRN0_OFS) |=> reg_rdata[1:0] ==
      {$past(txpwr_meas, 2) > dsaf_pkg::DSAF_WRN_HI[3],
       $past(txpwr_meas, 2) < dsaf_pkg::DSAF_WRN_LO[3]}
  ) else $error("Transmit power warning pair wrong");

  // Receive power warning byte with reserved bits clear
  a_rxpwr_warn: assert property (
    s_meas_rd(dsaf_pkg::DSAF_WRN1_OFS) |=> reg_rdata ==
      {$past(rxpwr_meas, 2) > dsaf_pkg::DSAF_WRN_HI[4],
       $past(rxpwr_meas, 2) < dsaf_pkg::DSAF_WRN_LO[4], 6'h00}
  ) else $error("Receive power warning byte wrong");

  // Just above 110 C raises both the high alarm and the high warning
  a_temp_limits: assert property (
    meas_strobe && temp_meas == 16'h6E01 |=> alm_hi_q[0] && wrn_hi_q[0]
  ) else $error("Temperature high limit wrong");

  // Most negative code is a cold reading, not a hot one
  a_temp_signed: assert property (
    meas_strobe && temp_meas == 16'h8000 |=> alm_lo_q[0] && !alm_hi_q[0]
  ) else $error("Temperature not compared signed");

  // Writes to flag bytes change nothing; flags hold between updates
  a_flags_ro: assert property (
    !meas_strobe |=> $stable(alm0_byte) && $stable(alm1_byte) &&
                     $stable(wrn0_byte) && $stable(wrn1_byte)
  ) else $error("Flag byte changed without update");

endmodule // dsaf_top

// ===== inc/dsaf_pkg.sv
// Purpose: Constants for the diagnostic status and alarm flag bank.
// Assumes: Byte-wide management memory port, thresholds fixed at defaults.
// Notes:   Channel order is temp, supply, bias, tx power, rx power.
package dsaf_pkg;

  // Number of monitored channels
  localparam int DSAF_NCH = 5;

  // Channel indices
  localparam int DSAF_CH_TEMP  = 0;
  localparam int DSAF_CH_VCC   = 1;
  localparam int DSAF_CH_BIAS  = 2;
  localparam int DSAF_CH_TXPWR = 3;
  localparam int DSAF_CH_RXPWR = 4;

  // Byte offsets in the diagnostic page
  localparam logic [7:0] DSAF_CTRL_OFS = 8'h6E;
  localparam logic [7:0] DSAF_ALM0_OFS = 8'h70;
  localparam logic [7:0] DSAF_ALM1_OFS = 8'h71;
  localparam logic [7:0] DSAF_WRN0_OFS = 8'h74;
  localparam logic [7:0] DSAF_WRN1_OFS = 8'h75;

  // Field positions in the status/control byte
  localparam int DSAF_TXS_STATE_BIT = 7;
  localparam int DSAF_TXS_SOFT_BIT  = 6;
  localparam int DSAF_LOS_BIT       = 1;
  localparam int DSAF_NRDY_BIT      = 0;

  // Values after reset and for unmapped reads
  localparam logic             DSAF_SOFT_RST  = 1'b0;
  localparam logic [DSAF_NCH-1:0] DSAF_FLAG_RST = 5'h00;
  localparam logic [7:0]       DSAF_RDATA_RST = 8'h00;
  localparam logic [7:0]       DSAF_UNMAPPED  = 8'h00;

  // Temperature thresholds in whole degrees, one degree is 256 counts
  localparam int DSAF_TEMP_LSB_PER_DEG = 256;
  localparam int DSAF_TEMP_ALM_HI_DEG  = 110;
  localparam int DSAF_TEMP_ALM_LO_DEG  = -45;
  localparam int DSAF_TEMP_WRN_HI_DEG  = 95;
  localparam int DSAF_TEMP_WRN_LO_DEG  = -42;
  localparam logic [15:0] DSAF_TEMP_ALM_HI = 16'(DSAF_TEMP_ALM_HI_DEG * DSAF_TEMP_LSB_PER_DEG);
  localparam logic [15:0] DSAF_TEMP_ALM_LO = 16'(DSAF_TEMP_ALM_LO_DEG * DSAF_TEMP_LSB_PER_DEG);
  localparam logic [15:0] DSAF_TEMP_WRN_HI = 16'(DSAF_TEMP_WRN_HI_DEG * DSAF_TEMP_LSB_PER_DEG);
  localparam logic [15:0] DSAF_TEMP_WRN_LO = 16'(DSAF_TEMP_WRN_LO_DEG * DSAF_TEMP_LSB_PER_DEG);

  // Thresholds per channel in raw measurement counts
  // Supply 100 uV, bias 2 uA, optical power 0.1 uW per count
  localparam logic [15:0] DSAF_ALM_HI [DSAF_NCH] =
    '{DSAF_TEMP_ALM_HI, 16'h8CA0, 16'hEA60, 16'h03E8, 16'h03E8};
  localparam logic [15:0] DSAF_ALM_LO [DSAF_NCH] =
    '{DSAF_TEMP_ALM_LO, 16'h6D60, 16'h1388, 16'h0032, 16'h0005};
  localparam logic [15:0] DSAF_WRN_HI [DSAF_NCH] =
    '{DSAF_TEMP_WRN_HI, 16'h88B8, 16'hD6D8, 16'h0277, 16'h0277};
  localparam logic [15:0] DSAF_WRN_LO [DSAF_NCH] =
    '{DSAF_TEMP_WRN_LO, 16'h7530, 16'h1D4C, 16'h003F, 16'h0006};

endpackage

// ===== logic/dsaf_compare.sv
// Purpose: Window comparison of one measurement against high and low limits.
// Assumes: Limits are constants; signedness chosen per channel.
// Notes:   Purely combinational; the caller registers the results.
module dsaf_compare #(
  parameter bit          IS_SIGNED = 1'b0,    // Two's complement compare
  parameter logic [15:0] LIM_HI    = 16'h0000, // High limit
  parameter logic [15:0] LIM_LO    = 16'h0000  // Low limit
) (
  input  wire logic [15:0] value,    // Measurement
  output logic             over_hi,  // Above high limit
  output logic             under_lo  // Below low limit
);

  // Strict comparisons in the chosen number format
  always_comb begin
    if (IS_SIGNED) begin
      over_hi  = $signed(value) > $signed(LIM_HI);
      under_lo = $signed(value) < $signed(LIM_LO);
    end else begin
      over_hi  = value > LIM_HI;
      under_lo = value < LIM_LO;
    end
  end

endmodule // dsaf_compare

// ===== logic/dsaf_ready.sv
// Purpose: Tracks whether measurement data has become valid since reset.
// Assumes: meas_strobe pulses once per fresh set of measurements.
// Notes:   Output is active low, as the host sees it.
module dsaf_ready (
  input  wire logic ref_clk,       // System clock
  input  wire logic rst_b,         // Async reset, active low
  input  wire logic meas_strobe,   // New measurement set
  output logic      data_valid_n   // Low once data is ready
);

  logic seen_q; // First measurement captured

  // Set on the first measurement and held until reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
    end else if (meas_strobe) begin
      seen_q <= 1'b1;
    end
  end

  // Active low view of readiness
  assign data_valid_n = ~seen_q;

endmodule // dsaf_ready

// ===== sim/dsaf_host_model.sv
// Purpose: Host side of the byte-wide management register port.
// Assumes: Requests are one-cycle strobes launched at the falling edge.
// Notes:   Released address and data lines show the inverse of their last value.
module dsaf_host_model (
  input  wire logic       ref_clk,    // System clock
  input  wire logic [7:0] reg_rdata,  // Read data from the bank
  input  wire logic       reg_rvalid, // Read data valid
  output logic      [7:0] reg_addr,   // Byte offset
  output logic            reg_wr,     // Write strobe
  output logic      [7:0] reg_wdata,  // Write data
  output logic            reg_rd      // Read strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One-cycle write; a write to the soft bit changes the shutoff state
  task automatic do_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~reg_addr;  // Released lines must not look valid
    reg_wdata = ~reg_wdata;
  endtask

  // One-cycle read; data taken while the valid pulse stands, else unknown
  task automatic do_read(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    reg_addr = ~reg_addr;
    d        = 8'hXX;
    for (i = 0; i < 4; i++) begin
      if (reg_rvalid === 1'b1) begin  // Answer seen
        d = reg_rdata;
        break;
      end
      @(negedge ref_clk);
    end
  endtask
endmodule // dsaf_host_model

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the status and alarm flag bank.
// Assumes: Inputs change at the falling edge; 20 MHz clock.
// Notes:   Expected flag bytes are worked out by hand from the limits.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int MAX_CYCLES = 3000;  // Whole run needs well under this
  // Measurement cases: temp, supply, bias, tx power, rx power
  localparam logic [15:0] MV [7][5] = '{
    '{16'h1900, 16'h80E8, 16'h4E20, 16'h0100, 16'h0100},  // Nominal
    '{16'h6E01, 16'h8CA1, 16'hEA61, 16'h03E9, 16'h03E9},  // Just above alarm high
    '{16'h6E00, 16'h8CA0, 16'hEA60, 16'h03E8, 16'h03E8},  // Equal to alarm high
    '{16'hD2FF, 16'h6D5F, 16'h1387, 16'h0031, 16'h0004},  // Just below alarm low
    '{16'hD400, 16'h6D60, 16'h1388, 16'h0032, 16'h0005},  // Between the low limits
    '{16'h1900, 16'h80E8, 16'h4E20, 16'h0100, 16'h0100},  // Back to nominal
    '{16'h8000, 16'h80E8, 16'h4E20, 16'h0100, 16'h0100}}; // Coldest signed code
  // Expected bytes at 0x70, 0x71, 0x74, 0x75 per case
  localparam logic [31:0] EXP [7] = '{32'h00000000, 32'hAA80AA80, 32'h0000AA80,
                                      32'h55405540, 32'h00005540, 32'h00000000,
                                      32'h40004000};

  logic        ref_clk;             // Clock
  logic        rst_b;               // Reset, active low
  logic [15:0] meas [5];            // Measurement inputs
  logic        meas_strobe;         // Fresh measurement pulse
  logic        receive_signal_lost; // Loss of signal pin
  logic [7:0]  reg_addr;            // Byte offset
  logic        reg_wr;              // Write strobe
  logic [7:0]  reg_wdata;           // Write data
  logic        reg_rd;              // Read strobe
  logic [7:0]  reg_rdata;           // Read data
  logic        reg_rvalid;          // Read valid
  logic        tx_shutoff;          // Soft shutoff output
  int          error_cnt;           // Mismatches
  int          n_tests;             // Comparisons
  int          cyc;                 // Cycle count for the timeout

  dsaf_top dsaf_top_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .temp_meas(meas[0]), .vcc_meas(meas[1]),
    .bias_meas(meas[2]), .txpwr_meas(meas[3]), .rxpwr_meas(meas[4]),
    .meas_strobe(meas_strobe), .receive_signal_lost(receive_signal_lost),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_shutoff(tx_shutoff));

  dsaf_host_model dsaf_host_model_inst (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  // Clock, half period 25 ns
  always #25 ref_clk = ~ref_clk;

  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == MAX_CYCLES) begin
      error_cnt++;
      $display("[ERR] timeout expected %0d cycles seen %0d", MAX_CYCLES, cyc);
      test_done();
    end
  end

  // Byte comparison
  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %02h seen %02h", nm, e, s);
    end
  endtask

  // Single-bit comparison
  task automatic check1(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask

  // Read one byte and compare it
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    dsaf_host_model_inst.do_read(a, d);
    check8(nm, e, d);
  endtask

  // Present one measurement set with a strobe pulse
  task automatic apply_meas(input int c);
    @(negedge ref_clk);
    for (int i = 0; i < 5; i++) meas[i] = MV[c][i];
    meas_strobe = 1'b1;
    @(negedge ref_clk);
    meas_strobe = 1'b0;
  endtask

  // Strobe one measurement set and read one offset in the very next cycle
  task automatic meas_rd(input int c, input string nm, input logic [7:0] a,
                         input logic [7:0] e);
    fork
      apply_meas(c);
      begin
        @(negedge ref_clk);
        rd_chk(nm, a, e);
      end
    join
  endtask

  // State straight after reset: not ready, no flags
  task automatic t_reset();
    check1("shutoff after reset", 1'b0, tx_shutoff);
    rd_chk("ctrl after reset", dsaf_pkg::DSAF_CTRL_OFS, 8'h01);
    rd_chk("alarm0 after reset", dsaf_pkg::DSAF_ALM0_OFS, 8'h00);
    rd_chk("warn1 after reset", dsaf_pkg::DSAF_WRN1_OFS, 8'h00);
    meas_rd(0, "ctrl once ready", dsaf_pkg::DSAF_CTRL_OFS, 8'h00);
    $display("test reset and ready done");
  endtask

  // Soft shutoff bit: write, mirror, ignored bits
  task automatic t_soft();
    dsaf_host_model_inst.do_write(dsaf_pkg::DSAF_CTRL_OFS, 8'h40);
    check1("shutoff set", 1'b1, tx_shutoff);
    rd_chk("ctrl soft set", dsaf_pkg::DSAF_CTRL_OFS, 8'hC0);
    dsaf_host_model_inst.do_write(dsaf_pkg::DSAF_CTRL_OFS, 8'hBF);
    check1("shutoff cleared", 1'b0, tx_shutoff);
    rd_chk("ctrl other bits", dsaf_pkg::DSAF_CTRL_OFS, 8'h00);
    $display("test soft shutoff done");
  endtask

  // Loss of signal pin mirrored live
  task automatic t_los();
    @(negedge ref_clk);
    receive_signal_lost = 1'b1;
    rd_chk("ctrl los high", dsaf_pkg::DSAF_CTRL_OFS, 8'h02);
    @(negedge ref_clk);
    receive_signal_lost = 1'b0;
    rd_chk("ctrl los low", dsaf_pkg::DSAF_CTRL_OFS, 8'h00);
    $display("test loss of signal done");
  endtask

  // Flags over boundary cases, latest result only
  task automatic t_flags();
    logic [7:0] ofs [4];
    ofs = '{dsaf_pkg::DSAF_ALM0_OFS, dsaf_pkg::DSAF_ALM1_OFS,
            dsaf_pkg::DSAF_WRN0_OFS, dsaf_pkg::DSAF_WRN1_OFS};
    for (int c = 0; c < 7; c++) begin
      for (int k = 0; k < 4; k++)
        meas_rd(c, $sformatf("flag byte %0d case %0d", k, c), ofs[k],
                EXP[c][31-8*k -: 8]);
    end
    $display("test flags done");
  endtask

  // Flag bytes refuse writes, unmapped places read zero
  task automatic t_refuse();
    apply_meas(1);
    dsaf_host_model_inst.do_write(dsaf_pkg::DSAF_ALM0_OFS, 8'h00);
    dsaf_host_model_inst.do_write(dsaf_pkg::DSAF_WRN1_OFS, 8'hFF);
    rd_chk("alarm0 after write", dsaf_pkg::DSAF_ALM0_OFS, 8'hAA);
    rd_chk("warn1 after write", dsaf_pkg::DSAF_WRN1_OFS, 8'h80);
    rd_chk("unmapped 6F", 8'h6F, 8'h00);
    rd_chk("unmapped 72", 8'h72, 8'h00);
    check1("shutoff untouched", 1'b0, tx_shutoff);
    $display("test refused writes done");
  endtask

  // Report counts, verdict and stop
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    ref_clk             = 1'b0;
    rst_b               = 1'b0;
    meas_strobe         = 1'b0;
    receive_signal_lost = 1'b0;
    for (int i = 0; i < 5; i++) meas[i] = 16'h0000;
    error_cnt = 0;
    n_tests   = 0;
    cyc       = 0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset();
    t_soft();
    t_los();
    t_flags();
    t_refuse();
    test_done();
  end
endmodule // tb_top
